/* verilog/pacfg_pkg.sv */
// constants, register map and types for the alarm and pin-config block
package pacfg_pkg;
  localparam int unsigned pacfg_n_ch = 4;
  // register byte addresses
  localparam logic [7:0] pacfg_a_sysctl = 8'h00;
  localparam logic [7:0] pacfg_a_pmu0 = 8'h04;
  localparam logic [7:0] pacfg_a_pmu3 = 8'h10;
  localparam logic [7:0] pacfg_a_alarm = 8'h14;
  localparam logic [7:0] pacfg_a_temp = 8'h18;
  localparam logic [7:0] pacfg_a_irq_stat = 8'h1c;
  localparam logic [7:0] pacfg_a_irq_en = 8'h20;
  localparam logic [7:0] pacfg_a_irq_clr = 8'h24;
  localparam logic [7:0] pacfg_a_live = 8'h28;
  // system control fields
  localparam int unsigned pacfg_b_gc_en = 0;
  localparam int unsigned pacfg_b_gc_latch = 1;
  localparam int unsigned pacfg_b_guard_en = 2;
  localparam int unsigned pacfg_b_clamp_en = 3;
  localparam int unsigned pacfg_b_lvds_cmp = 4;
  localparam logic [31:0] pacfg_sysctl_rst = 32'h0000_0010;
  // per-channel control fields
  localparam int unsigned pacfg_b_own_gnd = 0;
  localparam int unsigned pacfg_b_meas_lo = 1;
  localparam int unsigned pacfg_b_clear = 6;
  // measure selector codes
  localparam logic [1:0] pacfg_meas_volt = 2'h0;
  localparam logic [1:0] pacfg_meas_curr = 2'h1;
  localparam logic [1:0] pacfg_meas_temp = 2'h2;
  // temperature threshold, code in degrees celsius
  localparam int unsigned pacfg_temp_default_c = 130;
  localparam logic [7:0] pacfg_temp_rst = 8'(pacfg_temp_default_c);
  // interrupt status bits
  localparam int unsigned pacfg_i_guard = 0;
  localparam int unsigned pacfg_i_clamp = 1;
  localparam int unsigned pacfg_i_therm = 2;

  typedef struct packed {
    logic [31:0] sysctl;
    logic [3:0] own_gnd;
    logic [7:0] meas_sel;
    logic [3:0] guard_lat;
    logic [3:0] clamp_lat;
    logic therm_lat;
    logic gc_lat;
    logic [7:0] temp_thr;
    logic [2:0] irq_stat;
    logic [2:0] irq_en;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic gc_oe;
    logic therm_oe;
    logic lvds_mode;
    logic [3:0] cmp_diff;
    logic [3:0] guard_sel_hs;
    logic [3:0] gnd_sel_own;
    logic [7:0] meas_mux;
  } pacfg_state_t;
endpackage

/* verilog/pacfg_top.sv */
// alarm reporting and pin configuration for a four-channel pmu
//
// The APB register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps

// Notes on behaviour
// - guard/clamp alarm off until software enables it
// - control enables alarm, picks latched or live
// - alarm source: guard, clamp, or both
// - status: latched and live flag per source
// - thermal alarm active low, latched above threshold
// - status holds latched and live thermal flags
// - bit 6 write to any channel clears thermal
// - reset low returns all state to default
// - select pin low serial, high lvds
// - lvds mode turns comparator pins differential
// - shared low-sense ground unless channel uses own
// - measure output selects voltage, current, temperature
// - own-ground channel feeds guard from high sense
module pacfg_top
  import pacfg_pkg::*;
(
  input wire logic clk_sys, // system clock, 40 mhz
  input wire logic rst, // synchronous reset, active high
  input wire logic reset_pin_n, // device reset pin, active low
  input wire logic iface_sel, // low serial, high lvds
  input wire logic [3:0] guard_alarm_in, // live guard alarm per channel
  input wire logic [3:0] clamp_alarm_in, // live clamp alarm per channel
  input wire logic [7:0] temp_in, // junction temperature, celsius
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  output logic irq, // level interrupt
  output logic guard_clamp_alarm_out, // open-drain data, always 0
  output logic guard_clamp_alarm_oe, // pulls pin low when high
  output logic thermal_alarm_out, // open-drain data, always 0
  output logic thermal_alarm_oe, // pulls pin low when high
  output logic lvds_mode, // serial interface type
  output logic [3:0] cmp_diff_mode, // comparator pins differential
  output logic [3:0] guard_from_high_sense, // guard fed by high sense
  output logic [3:0] own_ground_sel, // channel uses own ground
  output logic [7:0] channel_measure_sel // 2 bits per channel
);

  pacfg_state_t s;
  pacfg_state_t next_s;

  // reset value of the whole state
  function automatic pacfg_state_t pacfg_reset_val();
    pacfg_state_t r;
    r = '0;
    r.sysctl = pacfg_sysctl_rst;
    r.temp_thr = pacfg_temp_rst;
    r.therm_oe = 1'b0;
    return r;
  endfunction

  // is address one of the channel registers
  function automatic logic pacfg_is_pmu(input logic [7:0] a);
    return a >= pacfg_a_pmu0 && a <= pacfg_a_pmu3 && a[1:0] == 2'h0;
  endfunction

  logic acc;
  logic wr;
  logic rd;
  logic [1:0] ch;
  logic therm_live;
  logic [3:0] guard_live;
  logic [3:0] clamp_live;
  logic gc_live;
  logic clr_therm;
  logic [2:0] ev;
  logic [7:0] alarm_word;
  logic mapped;

  always_comb
  begin
    next_s = s;
    acc = psel && penable && !s.pready;
    wr = acc && pwrite;
    rd = acc && !pwrite;
    ch = 2'((paddr - pacfg_a_pmu0) >> 2);
    mapped = paddr[1:0] == 2'h0 && paddr <= pacfg_a_live;
    therm_live = temp_in > s.temp_thr;
    guard_live = guard_alarm_in & {4{s.sysctl[pacfg_b_guard_en]}};
    clamp_live = clamp_alarm_in & {4{s.sysctl[pacfg_b_clamp_en]}};
    gc_live = |guard_live || |clamp_live;
    clr_therm = wr && pacfg_is_pmu(paddr) && pwdata[pacfg_b_clear];
    alarm_word = {s.guard_lat, s.clamp_lat};
    // ------------------------------------------------------------
    // alarm latches, set wins over clear
    // ------------------------------------------------------------
    next_s.guard_lat = s.guard_lat | guard_alarm_in;
    next_s.clamp_lat = s.clamp_lat | clamp_alarm_in;
    if (clr_therm)
    begin
      next_s.guard_lat = guard_alarm_in;
      next_s.clamp_lat = clamp_alarm_in;
      next_s.gc_lat = 1'b0;
    end
    next_s.therm_lat = (s.therm_lat && !clr_therm) || therm_live;
    if (gc_live && s.sysctl[pacfg_b_gc_en])
      next_s.gc_lat = 1'b1;
    // ------------------------------------------------------------
    // interrupt status
    // ------------------------------------------------------------
    ev = {therm_live && !s.therm_lat, |guard_alarm_in, |clamp_alarm_in};
    ev = {ev[2], ev[0], ev[1]};
    if (wr && paddr == pacfg_a_irq_clr)
      next_s.irq_stat = s.irq_stat & ~pwdata[2:0];
    next_s.irq_stat = next_s.irq_stat | ev;
    next_s.irq = |(next_s.irq_stat & next_s.irq_en);
    // ------------------------------------------------------------
    // apb slave, one wait state
    // ------------------------------------------------------------
    next_s.pready = acc;
    next_s.pslverr = acc && !mapped;
    next_s.prdata = '0;
    if (wr)
    begin
      if (paddr == pacfg_a_sysctl)
        next_s.sysctl = pwdata;
      else if (pacfg_is_pmu(paddr))
      begin
        next_s.own_gnd[ch] = pwdata[pacfg_b_own_gnd];
        next_s.meas_sel[2*ch +: 2] = pwdata[pacfg_b_meas_lo +: 2];
      end
      else if (paddr == pacfg_a_temp)
        next_s.temp_thr = pwdata[7:0];
      else if (paddr == pacfg_a_irq_en)
        next_s.irq_en = pwdata[2:0];
    end
    if (rd)
    begin
      if (paddr == pacfg_a_sysctl)
        next_s.prdata = s.sysctl;
      else if (pacfg_is_pmu(paddr))
        next_s.prdata = {25'h0, 4'h0, s.meas_sel[2*ch +: 2],
                         s.own_gnd[ch]};
      else if (paddr == pacfg_a_alarm)
        next_s.prdata = {14'h0, therm_live, s.therm_lat,
                         guard_alarm_in, clamp_alarm_in, alarm_word};
      else if (paddr == pacfg_a_temp)
        next_s.prdata = {24'h0, s.temp_thr};
      else if (paddr == pacfg_a_irq_stat)
        next_s.prdata = {29'h0, s.irq_stat};
      else if (paddr == pacfg_a_irq_en)
        next_s.prdata = {29'h0, s.irq_en};
      else if (paddr == pacfg_a_live)
        next_s.prdata = {24'h0, temp_in};
    end
    // ------------------------------------------------------------
    // pin outputs
    // ------------------------------------------------------------
    next_s.gc_oe = s.sysctl[pacfg_b_gc_en] &&
                   (s.sysctl[pacfg_b_gc_latch] ? next_s.gc_lat : gc_live);
    next_s.therm_oe = next_s.therm_lat;
    next_s.lvds_mode = iface_sel;
    next_s.cmp_diff = {4{iface_sel && s.sysctl[pacfg_b_lvds_cmp]}};
    next_s.gnd_sel_own = s.own_gnd;
    next_s.guard_sel_hs = s.own_gnd;
    next_s.meas_mux = s.meas_sel;
    if (rst || !reset_pin_n)
      next_s = pacfg_reset_val();
  end

  always_ff @(posedge clk_sys)
    s <= next_s;

  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign irq = s.irq;
  assign guard_clamp_alarm_out = 1'b0;
  assign guard_clamp_alarm_oe = s.gc_oe;
  assign thermal_alarm_out = 1'b0;
  assign thermal_alarm_oe = s.therm_oe;
  assign lvds_mode = s.lvds_mode;
  assign cmp_diff_mode = s.cmp_diff;
  assign guard_from_high_sense = s.guard_sel_hs;
  assign own_ground_sel = s.gnd_sel_own;
  assign channel_measure_sel = s.meas_mux;

endmodule

/* test/pacfg_ctrl_model.sv */
// controller-side view of the two open-drain alarm pins
`timescale 1ns/1ps
module pacfg_ctrl_model (
  input wire logic guard_clamp_alarm_out, // pin data
  input wire logic guard_clamp_alarm_oe, // pin pull
  input wire logic thermal_alarm_out, // pin data
  input wire logic thermal_alarm_oe, // pin pull
  output wire logic gc_pin, // resolved level
  output wire logic tm_pin // resolved level
);
  // board pull-up wins while nobody pulls low
  assign gc_pin = guard_clamp_alarm_oe ? guard_clamp_alarm_out : 1'b1;
  assign tm_pin = thermal_alarm_oe ? thermal_alarm_out : 1'b1;
endmodule

/* test/pacfg_properties.sv */
// concurrent checks on the alarm and pin-config ports
`timescale 1ns/1ps
module pacfg_properties (
  input wire logic clk_sys, // clock
  input wire logic rst, // reset
  input wire logic reset_pin_n, // reset pin
  input wire logic iface_sel, // select pin
  input wire logic psel, // apb
  input wire logic penable, // apb
  input wire logic pwrite, // apb
  input wire logic pready, // apb
  input wire logic guard_clamp_alarm_out, // data
  input wire logic guard_clamp_alarm_oe, // pull
  input wire logic thermal_alarm_out, // data
  input wire logic thermal_alarm_oe, // pull
  input wire logic lvds_mode, // iface
  input wire logic [3:0] cmp_diff_mode, // cmp
  input wire logic [3:0] guard_from_high_sense, // guard
  input wire logic [3:0] own_ground_sel // ground
);
  wire logic rs = rst || !reset_pin_n;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rs);
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("ready held");
  property p_ans; psel && penable && !pready |=> pready; endproperty
  a_ans: assert property (p_ans) else $error("no answer");
  property p_od; !guard_clamp_alarm_out && !thermal_alarm_out; endproperty
  a_od: assert property (p_od) else $error("pin driven high");
  property p_sel; !$past(rs) |-> lvds_mode == $past(iface_sel); endproperty
  a_sel: assert property (p_sel) else $error("mode lag");
  property p_cmp; |cmp_diff_mode |-> &cmp_diff_mode && lvds_mode; endproperty
  a_cmp: assert property (p_cmp) else $error("cmp pins");
  property p_gnd; guard_from_high_sense == own_ground_sel; endproperty
  a_gnd: assert property (p_gnd) else $error("guard source");
  property p_off; $past(rs) |-> !guard_clamp_alarm_oe[*2]; endproperty
  a_off: assert property (p_off) else $error("alarm on at reset");
  property p_tc; !$past(rs) && $fell(thermal_alarm_oe) |->
    $past(pwrite) || $past(pwrite, 2) || $past(pwrite, 3); endproperty
  a_tc: assert property (p_tc) else $error("thermal drop");
endmodule
bind pacfg_top pacfg_properties u_props (.*);

/* test/pacfg_top_bench.sv */
// self-checking bench for the alarm and pin-config block
`timescale 1ns/1ps
module pacfg_top_bench;
  logic clk_sys, rst, reset_pin_n, iface_sel, psel, penable, pwrite;
  logic [3:0] guard_alarm_in, clamp_alarm_in;
  logic [7:0] temp_in, paddr, channel_measure_sel;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, irq, er, lvds_mode, gc_pin, tm_pin;
  logic guard_clamp_alarm_out, guard_clamp_alarm_oe;
  logic thermal_alarm_out, thermal_alarm_oe;
  logic [3:0] cmp_diff_mode, guard_from_high_sense, own_ground_sel;
  int errors = 0;
  int num_checks = 0;
  pacfg_top dut (.*);
  pacfg_ctrl_model ctrl (.*);
  task finish_test;
    $display("errors %0d checks %0d", errors, num_checks);
    if (errors == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e)
    begin
      errors++;
      $display("BAD %0t got %h want %h", $time, s, e);
    end
  endtask
  task wt(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, logic [31:0] d);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
    @(posedge clk_sys);
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task pin(input logic g, input logic t);
    wt(2);
    chk(32'(gc_pin), 32'(g));
    chk(32'(tm_pin), 32'(t));
  endtask
  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  initial
  begin
    wt(3000);
    errors++;
    finish_test;
  end
  initial
  begin
    {rst, reset_pin_n, iface_sel, psel, penable, pwrite} = 6'b110000;
    {guard_alarm_in, clamp_alarm_in, paddr, pwdata} = '0;
    temp_in = 8'h19;
    wt(20);
    rst <= 1'b0;
    wt(1);
    rdc(8'h00, 32'h10);
    rdc(8'h18, 32'h82);
    apb(1'b0, 8'h2c, 32'h0);
    chk(32'(er), 32'h1);
    rdc(8'h28, 32'h19);
    guard_alarm_in <= 4'h1;
    pin(1'b1, 1'b1);
    rdc(8'h14, 32'h1010);
    apb(1'b1, 8'h00, 32'h15);
    pin(1'b0, 1'b1);
    apb(1'b1, 8'h00, 32'h19);
    pin(1'b1, 1'b1);
    clamp_alarm_in <= 4'h2;
    pin(1'b0, 1'b1);
    apb(1'b1, 8'h00, 32'h1b);
    {guard_alarm_in, clamp_alarm_in} <= 8'h0;
    pin(1'b0, 1'b1);
    apb(1'b1, 8'h0c, 32'h40);
    pin(1'b1, 1'b1);
    temp_in <= 8'h83;
    pin(1'b1, 1'b0);
    rdc(8'h14, 32'h30000);
    temp_in <= 8'h19;
    pin(1'b1, 1'b0);
    rdc(8'h14, 32'h10000);
    apb(1'b1, 8'h10, 32'h40);
    pin(1'b1, 1'b1);
    apb(1'b1, 8'h18, 32'h14);
    pin(1'b1, 1'b0);
    apb(1'b1, 8'h18, 32'h82);
    apb(1'b1, 8'h04, 32'h40);
    pin(1'b1, 1'b1);
    chk(32'(irq), 32'h0);
    rdc(8'h1c, 32'h7);
    apb(1'b1, 8'h20, 32'h4);
    wt(2);
    chk(32'(irq), 32'h1);
    apb(1'b1, 8'h24, 32'h7);
    wt(2);
    chk(32'(irq), 32'h0);
    for (int k = 0; k < 3; k++)
      apb(1'b1, 8'(4 + 4 * k), 32'(2 * k + (k == 1)));
    wt(1);
    chk(32'(channel_measure_sel), 32'h24);
    chk(32'(own_ground_sel), 32'h2);
    chk(32'(guard_from_high_sense), 32'h2);
    iface_sel <= 1'b1;
    wt(2);
    chk(32'(lvds_mode), 32'h1);
    chk(32'(cmp_diff_mode), 32'hf);
    reset_pin_n <= 1'b0;
    wt(1);
    reset_pin_n <= 1'b1;
    wt(1);
    rdc(8'h00, 32'h10);
    chk(32'(own_ground_sel), 32'h0);
    finish_test;
  end
endmodule
